/* crce_map.vh */
// register map, field positions and reset values of the crc control block
`ifndef CRCE_MAP_VH
`define CRCE_MAP_VH
`define CRCE_OFS_CTRL 12'h000
`define CRCE_OFS_DATA 12'h004
`define CRCE_OFS_POLY_LENGTH 12'h008
`define CRCE_OFS_STAT 12'h00C
`define CRCE_OFS_MASK 12'h010
`define CRCE_BIT_EN 15
`define CRCE_BIT_IDLE 13
`define CRCE_VW_HI 12
`define CRCE_VW_LO 8
`define CRCE_BIT_FULL 7
`define CRCE_BIT_EMPTY 6
`define CRCE_BIT_ISEL 5
`define CRCE_BIT_GO 4
`define CRCE_BIT_LSB 3
`define CRCE_CTRL_WMASK 16'hA038
`define CRCE_CTRL_RESET 16'h0040
`define CRCE_POLY_LENGTH_W 5
`define CRCE_POLY_LENGTH_SMALL 5'h07
`define CRCE_DEPTH_BIG 5'h10
`define CRCE_DEPTH_SMALL 5'h08
`define CRCE_IRQ_BIT 0
`endif

/* crce_ctrl.v */
// control, status, input fifo and serial shifter of the programmable crc engine
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
// Functional notes
// - with the module enable cleared, shifter, fifo pointers and input words are held reset.
// - with halt-in-idle set, operation pauses while the chip is in idle mode.
// - bits 12..8 read the number of valid words held in the input fifo.
// - fifo capacity is 8 words for poly length above 7 and 16 words otherwise.
// - the full flag is high exactly when the fifo holds its capacity or more, reset low.
// - the empty flag is high exactly when the fifo holds no word, reset high.
// - interrupt source is fifo-drained with select set, else shift-complete.
// - the shifter runs only while the go bit is one and stops when it is cleared.
// - lsb-first select one feeds each word lsb first, zero feeds msb first.
// - control bits 14 and 2..0 read zero and ignore writes.
`include "crce_map.vh"
module crce_ctrl #(
  parameter DW = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire idle_mode_in,
  output reg [31:0] prdata_out,
  output reg pready_out,
  output reg pslverr_out,
  output reg irq_out,
  output reg shift_bit_out,
  output reg shift_valid_out,
  output reg word_start_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_SHIFT = 2'b10;
  localparam CW = 5;
  localparam BW = 5;

  // decoded register select, shared by the read mux and the write strobes
  function [4:0] reg_sel;
    input [11:0] a;
    begin
      reg_sel = 5'h00;
      case (a)
        `CRCE_OFS_CTRL: reg_sel = 5'h01;
        `CRCE_OFS_DATA: reg_sel = 5'h02;
        `CRCE_OFS_POLY_LENGTH: reg_sel = 5'h04;
        `CRCE_OFS_STAT: reg_sel = 5'h08;
        `CRCE_OFS_MASK: reg_sel = 5'h10;
        default: reg_sel = 5'h00;
      endcase
    end
  endfunction

  reg [15:0] ctrl_q;
  reg [`CRCE_POLY_LENGTH_W-1:0] poly_length_q;
  reg stat_q;
  reg mask_q;
  reg [DW-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wptr_q;
  reg [AW-1:0] rptr_q;
  reg [CW-1:0] count_q;
  reg [CW-1:0] count_d;
  reg full_q;
  reg empty_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [DW-1:0] sreg_q;
  reg [BW-1:0] bits_q;
  reg [31:0] rdata_d;

  wire [4:0] sel;
  wire acc;
  wire wr_en;
  wire en;
  wire run;
  wire lsb_first;
  wire [CW-1:0] cap;
  wire push;
  wire pop;
  wire last_bit;
  wire ev_drain;
  wire ev_done;
  wire event_hit;
  wire [15:0] ctrl_rd;
  wire acc_first;
  wire stat_clr;
  wire stat_d;
  wire full_d;
  wire empty_d;
  wire shift_now;

  assign sel = reg_sel(paddr_in);
  // a write lands on the edge where pready is sampled high
  assign acc = psel_in & penable_in & pready_out;
  assign wr_en = acc & pwrite_in;
  // first access-phase cycle: the slave answers on the following edge
  assign acc_first = psel_in & penable_in & ~pready_out;
  assign en = ctrl_q[`CRCE_BIT_EN];
  assign run = en & ctrl_q[`CRCE_BIT_GO] & ~(ctrl_q[`CRCE_BIT_IDLE] & idle_mode_in);
  assign lsb_first = ctrl_q[`CRCE_BIT_LSB];
  assign cap = (poly_length_q > `CRCE_POLY_LENGTH_SMALL) ? `CRCE_DEPTH_SMALL : `CRCE_DEPTH_BIG;
  // pushes beyond capacity are dropped; software is expected to poll the full flag
  assign push = wr_en & sel[1] & en & ~full_q;
  assign pop = run & ~empty_q & (state_q == ST_IDLE);
  assign last_bit = (state_q == ST_SHIFT) & run & (bits_q == DW - 1);
  assign ev_drain = pop & (count_q == 5'h01) & ~push;
  assign ev_done = last_bit & empty_q & ~push;
  assign event_hit = ctrl_q[`CRCE_BIT_ISEL] ? ev_drain : ev_done;
  // write one to clear the status bit
  assign stat_clr = wr_en & sel[3] & pwdata_in[`CRCE_IRQ_BIT];
  // a new event beats a clear in the same cycle
  assign stat_d = event_hit | (stat_q & ~stat_clr);
  // full at capacity; a lowered capacity must not let pushes overrun
  assign full_d = (count_d >= cap);
  assign empty_d = (count_d == 5'h00);
  // a bit of the current word leaves in this cycle
  assign shift_now = (state_q == ST_SHIFT) & run;

  assign ctrl_rd = {ctrl_q[15], 1'b0, ctrl_q[13], count_q, full_q, empty_q,
                    ctrl_q[5:3], 3'h0};

  always @* begin
    count_d = count_q;
    if (push & ~pop) begin
      count_d = count_q + 5'h01;
    end else if (pop & ~push) begin
      count_d = count_q - 5'h01;
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (pop) begin
          state_d = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (last_bit) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // storage is cleared with the pointers so no stale word survives a disable
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_mem
      always @(posedge ref_clk_in) begin
        if (!rst_n_in || !en) begin
          mem_q[gi] <= {DW{1'b0}};
        end else if (push && (wptr_q == gi)) begin
          mem_q[gi] <= pwdata_in[DW-1:0];
        end
      end
    end
  endgenerate

  // apb slave: one wait state, data registered with pready
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= acc_first;
    end
  end

  // unmapped offsets answer with an error and no data
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pslverr_out <= 1'b0;
    end else begin
      pslverr_out <= acc_first & (sel == 5'h00);
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    case (sel)
      5'h01: rdata_d = {16'h0000, ctrl_rd};
      5'h04: rdata_d = {27'h0, poly_length_q};
      5'h08: rdata_d = {31'h0, stat_q};
      5'h10: rdata_d = {31'h0, mask_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // read data stands only beside pready, zero otherwise
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (acc_first & ~pwrite_in) begin
      prdata_out <= rdata_d;
    end else begin
      prdata_out <= 32'h0000_0000;
    end
  end

  // configuration registers survive a disable
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `CRCE_CTRL_RESET;
    end else if (wr_en & sel[0]) begin
      ctrl_q <= pwdata_in[15:0] & `CRCE_CTRL_WMASK;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      poly_length_q <= 5'h00;
    end else if (wr_en & sel[2]) begin
      poly_length_q <= pwdata_in[`CRCE_POLY_LENGTH_W-1:0];
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mask_q <= 1'b0;
    end else if (wr_en & sel[4]) begin
      mask_q <= pwdata_in[`CRCE_IRQ_BIT];
    end
  end

  // sticky event, write one to clear
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      stat_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
    end
  end

  // level interrupt from the unmasked status bit
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= stat_d & mask_q;
    end
  end

  // fifo pointers and flags
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      wptr_q <= {AW{1'b0}};
    end else if (push) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      rptr_q <= {AW{1'b0}};
    end else if (pop) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end

  // flags come from the next count so they move with it
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      count_q <= 5'h00;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      count_q <= count_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end

  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit counter restarts with every word taken from the fifo
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      bits_q <= 5'h00;
    end else if (pop) begin
      bits_q <= 5'h00;
    end else if (shift_now) begin
      bits_q <= bits_q + 5'h01;
    end
  end

  // serial shifter; a cleared go bit freezes it mid-word
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      sreg_q <= {DW{1'b0}};
      shift_bit_out <= 1'b0;
    end else if (pop) begin
      sreg_q <= mem_q[rptr_q];
    end else if (shift_now) begin
      if (lsb_first) begin
        shift_bit_out <= sreg_q[0];
        sreg_q <= {1'b0, sreg_q[DW-1:1]};
      end else begin
        shift_bit_out <= sreg_q[DW-1];
        sreg_q <= {sreg_q[DW-2:0], 1'b0};
      end
    end
  end

  // strobes that qualify the serial bit
  always @(posedge ref_clk_in) begin
    if (!rst_n_in || !en) begin
      shift_valid_out <= 1'b0;
      word_start_out <= 1'b0;
    end else begin
      shift_valid_out <= shift_now;
      word_start_out <= shift_now & (bits_q == 5'h00);
    end
  end

endmodule

/* crce_ctrl_sva.sv */
// port checker for the crc control block
`timescale 1ns/10ps
module crce_chk (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [11:0] paddr_in,
  input wire [31:0] prdata_out,
  input wire pready_out,
  input wire pslverr_out,
  input wire irq_out,
  input wire shift_valid_out,
  input wire word_start_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd_ctrl = pready_out && !pwrite_in && paddr_in == 12'h000;
  chk_one_wait: assert property (psel_in && penable_in && !$past(penable_in) |=> pready_out)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  chk_err_unmapped: assert property (pready_out |-> pslverr_out == !(paddr_in == 12'h000 ||
    paddr_in == 12'h004 || paddr_in == 12'h008 || paddr_in == 12'h00C || paddr_in == 12'h010))
    else $error("error response wrong");
  chk_err_alone: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  chk_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  chk_ctrl_reserved: assert property (
    rd_ctrl |-> prdata_out[14] == 1'b0 && prdata_out[2:0] == 3'h0 && prdata_out[31:16] == 16'h0)
    else $error("reserved bits not zero");
  chk_empty_count: assert property (rd_ctrl |-> prdata_out[6] == (prdata_out[12:8] == 5'h00))
    else $error("empty flag and count disagree");
  chk_count_max: assert property (
    rd_ctrl |-> prdata_out[12:8] <= 5'h10 && !(prdata_out[7] && prdata_out[12:8] < 5'h08))
    else $error("count beyond capacity");
  chk_word_gap: assert property (word_start_out |-> shift_valid_out ##1 !word_start_out[*8])
    else $error("word start too soon");
  cover property (pslverr_out);
  cover property (word_start_out);
  cover property ($rose(irq_out));
endmodule
bind crce_ctrl crce_chk u_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .irq_out(irq_out), .shift_valid_out(shift_valid_out), .word_start_out(word_start_out));

/* crce_ctrl_tb_top.sv */
// self-checking bench for the crc control block
`timescale 1ns/10ps
module crce_ctrl_tb_top;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, idle = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, perr, irq, sbit, sval, wst;
  logic [15:0] cap = 16'h0, w;
  integer nb = 0, err_count = 0, checks = 0, seed = 32'hc07a75ce, i, k;
  integer nb0 = 0, ws = 0;
  crce_ctrl dut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .idle_mode_in(idle),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .irq_out(irq),
    .shift_bit_out(sbit), .shift_valid_out(sval), .word_start_out(wst));
  initial forever #25 clk = ~clk;
  always @(posedge clk) if (sval) begin
    cap <= {cap[14:0], sbit};
    nb <= nb + 1;
    if (wst) ws <= nb;
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // master holds the request until the edge where ready is seen
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  function logic [31:0] ctrl_exp(input logic [15:0] c, input logic [4:0] n, input logic [4:0] d);
    ctrl_exp = {16'h0, c & 16'hA038} | {19'h0, n, 8'h0} | {24'h0, n == d, n == 5'h0, 6'h0};
  endfunction
  function logic [15:0] bits_exp(input logic [15:0] v, input logic lsb);
    integer j;
    bits_exp = v;
    if (lsb) for (j = 0; j < 16; j++) bits_exp[j] = v[15-j];
  endfunction
  task stop_test;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    apb(0, 12'h000, 0);
    cmp(rd, ctrl_exp(16'h0, 0, 16));
    apb(1, 12'h000, 32'hFFFFFFFF);
    apb(0, 12'h000, 0);
    cmp(rd, ctrl_exp(16'hFFFF, 0, 16));
    apb(1, 12'h000, 32'h8000);
    // the seventeenth word finds the fifo full and is dropped
    for (i = 0; i < 17; i++) apb(1, 12'h004, $random(seed));
    apb(0, 12'h000, 0);
    cmp(rd, ctrl_exp(16'h8000, 16, 16));
    apb(1, 12'h008, 8);
    apb(1, 12'h000, 0);
    apb(0, 12'h000, 0);
    cmp(rd, ctrl_exp(16'h0, 0, 8));
    apb(1, 12'h000, 32'h8000);
    for (i = 0; i < 9; i++) apb(1, 12'h004, $random(seed));
    apb(0, 12'h000, 0);
    cmp(rd, ctrl_exp(16'h8000, 8, 8));
    apb(1, 12'h008, 0);
    apb(1, 12'h000, 0);
    apb(0, 12'h014, 0);
    cmp({er, rd[30:0]}, 32'h80000000);
    apb(1, 12'h010, 1);
    for (k = 0; k < 2; k++) begin
      nb0 = nb;
      apb(1, 12'h000, 32'h8000);
      w = $random(seed);
      apb(1, 12'h004, {16'h0, w});
      idle <= 1;
      apb(1, 12'h000, 32'hA010 | (k << 3) | (k << 5));
      repeat (20) @(posedge clk);
      cmp(nb - nb0, 0);
      idle <= 0;
      for (i = 0; i < 100 && nb - nb0 < 8; i++) @(negedge clk);
      cmp({31'h0, irq}, k);
      for (i = 0; i < 100 && nb - nb0 < 16; i++) @(negedge clk);
      cmp(cap, bits_exp(w, k));
      cmp(ws, nb0);
      repeat (3) @(negedge clk);
      cmp({31'h0, irq}, 1);
      @(posedge clk);
      apb(1, 12'h00C, 1);
      repeat (2) @(negedge clk);
      cmp({31'h0, irq}, 0);
      @(posedge clk);
    end
    // clearing go freezes the shifter mid-word, setting it again resumes the word
    apb(1, 12'h000, 32'h8000);
    nb0 = nb;
    w = $random(seed);
    apb(1, 12'h004, {16'h0, w});
    apb(1, 12'h000, 32'h8010);
    while (nb - nb0 < 4) @(posedge clk);
    apb(1, 12'h000, 32'h8000);
    repeat (2) @(posedge clk);
    k = nb;
    repeat (10) @(posedge clk);
    cmp(nb, k);
    apb(1, 12'h000, 32'h8010);
    for (i = 0; i < 100 && nb - nb0 < 16; i++) @(negedge clk);
    cmp(cap, w);
    cmp(ws, nb0);
    cmp({31'h0, irq}, 1);
    stop_test;
  end
endmodule
